// file: include/civf_defs.vh
// Constants for the CAN interrupt code and filter control slice.
// Assumes a plain word-wide register port with byte addresses.
`ifndef CIVF_DEFS_VH
`define CIVF_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CIVF_ADDR_W          4
`define CIVF_OFS_INT_FLAGS   4'h0
`define CIVF_OFS_INT_MASK    4'h4
`define CIVF_OFS_INT_CODE    4'h8
`define CIVF_OFS_FILTER_CTRL 4'hC

// ----------------------------------------------------------------
// Flag register bit positions (mask register shares the layout)
// ----------------------------------------------------------------
`define CIVF_FLAG_W          16
`define CIVF_BIT_INVALID     15
`define CIVF_BIT_WAKE        14
`define CIVF_BIT_BUS_ERR     13
`define CIVF_BIT_SYS_ERR     12
`define CIVF_BIT_RX_OVF      11
`define CIVF_BIT_MODE        3
`define CIVF_BIT_TIMER       2
`define CIVF_BIT_RX_PEND     1
`define CIVF_BIT_TX_PEND     0
`define CIVF_STICKY_MASK     16'hF80C
`define CIVF_IMPL_MASK       16'hF80F
`define CIVF_FLAG_RESET      16'h0000

// ----------------------------------------------------------------
// Interrupt code register layout and codes
// ----------------------------------------------------------------
`define CIVF_HIT_LSB         8
`define CIVF_HIT_W           5
`define CIVF_CODE_W          7
`define CIVF_CODE_NONE       7'h40
`define CIVF_CODE_BUS_ERR    7'h41
`define CIVF_CODE_WAKE       7'h42
`define CIVF_CODE_RX_OVF     7'h43
`define CIVF_CODE_ADDR_ERR   7'h44
`define CIVF_CODE_BW_ERR     7'h45
`define CIVF_CODE_TIMER      7'h46
`define CIVF_CODE_INVALID    7'h48
`define CIVF_CODE_MODE       7'h4F
`define CIVF_FIFO_PAD        2'h0

// ----------------------------------------------------------------
// Filter control byte layout
// ----------------------------------------------------------------
`define CIVF_NUM_FILTERS     4
`define CIVF_FLT_BYTE_W      8
`define CIVF_FLT_EN_BIT      7
`define CIVF_FLT_MASK_SELECT_LSB    5
`define CIVF_FLT_MASK_SELECT_W      2
`define CIVF_FLT_FIFO_SELECT_LSB    0
`define CIVF_FLT_FIFO_SELECT_W      5
`define CIVF_FLT_RESET       32'h0000_0000
`define CIVF_MASK_COUNT      4

// ----------------------------------------------------------------
// Misc widths and reset values
// ----------------------------------------------------------------
`define CIVF_DATA_W          32
`define CIVF_MODE_W          3
`define CIVF_FIFO_COUNT      32
`define CIVF_ZERO32          32'h0000_0000

`endif

// file: verilog/civf_top.v
// CAN interrupt flags, interrupt code and filter control for filters 16-19.
// Assumes event pulses and levels come from logic on i_clk, except the
// CAN receive pin, which is asynchronous and is synchronised here.
`timescale 1ns/1ps
`include "civf_defs.vh"

module civf_top #(
  parameter TIMER_W        = 16,
  parameter TIMER_PRESCALE = 1
) (
  input  wire                        i_clk,
  input  wire                        i_nrst,
  // Register port
  input  wire [`CIVF_ADDR_W-1:0]     i_addr,
  input  wire [`CIVF_DATA_W-1:0]     i_wdata,
  input  wire                        i_wr,
  input  wire                        i_rd,
  output reg  [`CIVF_DATA_W-1:0]     o_rdata,
  output reg                         o_irq,
  // CAN side and controller events
  input  wire                        i_can_rx,
  input  wire                        i_sleep_mode,
  input  wire                        i_bus_error_event,
  input  wire                        i_address_error_event,
  input  wire                        i_bandwidth_error_event,
  input  wire                        i_receive_overflow_event,
  input  wire                        i_invalid_message_event,
  input  wire [`CIVF_MODE_W-1:0]     i_current_operating_mode,
  input  wire [`CIVF_MODE_W-1:0]     i_requested_operating_mode,
  input  wire                        i_receive_pending,
  input  wire                        i_transmit_pending,
  input  wire [`CIVF_FIFO_COUNT-1:0] i_fifo_interrupt_status,
  input  wire                        i_filter_hit_valid,
  input  wire [`CIVF_HIT_W-1:0]      i_filter_hit_number,
  // Filter settings for the matching engine, then the timestamp timer
  output reg  [`CIVF_NUM_FILTERS-1:0]                   o_filter_enable,
  output reg  [`CIVF_NUM_FILTERS*`CIVF_MASK_COUNT-1:0]  o_filter_mask_decode,
  output reg  [`CIVF_NUM_FILTERS*`CIVF_FLT_FIFO_SELECT_W-1:0]  o_filter_fifo_select,
  output reg  [TIMER_W-1:0]                             o_timestamp_timer
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam [TIMER_W-1:0] TIMER_MAX   = {TIMER_W{1'b1}};
  localparam [TIMER_W-1:0] TIMER_ONE   = {{(TIMER_W-1){1'b0}}, 1'b1};
  localparam [15:0]        PRESCALE_LAST = TIMER_PRESCALE[15:0] - 16'h0001;

  reg  [`CIVF_FLAG_W-1:0]  flags;
  reg  [`CIVF_FLAG_W-1:0]  mask;
  reg  [`CIVF_FLAG_W-1:0]  next_flags;
  reg  [`CIVF_FLAG_W-1:0]  flag_set;
  reg                      addr_err_pend;
  reg                      bw_err_pend;
  reg  [`CIVF_HIT_W-1:0]   matched_filter_number;
  reg  [`CIVF_CODE_W-1:0]  interrupt_code;
  reg  [`CIVF_CODE_W-1:0]  next_interrupt_code;
  reg  [`CIVF_DATA_W-1:0]  filter_control;
  reg  [`CIVF_DATA_W-1:0]  next_filter_control;
  reg  [`CIVF_DATA_W-1:0]  next_rdata;
  reg  [15:0]              prescale_cnt;
  reg                      mode_match_d;
  reg                      rx_meta;
  reg                      rx_sync2;
  reg                      rx_sync3;
  reg                      rx_stable;
  reg                      rx_stable_d;
  reg  [4:0]               fifo_idx;
  reg                      fifo_hit;
  integer                  k;

  wire [`CIVF_FLAG_W-1:0]  enabled_flags;
  wire                     rd_flags;
  wire                     wr_mask;
  wire                     wr_filter;
  wire                     mode_match;
  wire                     timer_tick;
  wire                     timer_wrap;
  wire                     wake_edge;
  wire                     fifo_enabled;

  assign rd_flags      = i_rd && (i_addr == `CIVF_OFS_INT_FLAGS);
  assign wr_mask       = i_wr && (i_addr == `CIVF_OFS_INT_MASK);
  assign wr_filter     = i_wr && (i_addr == `CIVF_OFS_FILTER_CTRL);
  assign enabled_flags = flags & mask;
  assign mode_match    = (i_current_operating_mode == i_requested_operating_mode);
  assign timer_tick    = (prescale_cnt == PRESCALE_LAST);
  assign timer_wrap    = timer_tick && (o_timestamp_timer == TIMER_MAX);
  // Dominant level after a recessive one counts as bus activity
  assign wake_edge     = rx_stable_d && !rx_stable;
  // FIFO interrupts ride on either buffer pending enable
  assign fifo_enabled  = mask[`CIVF_BIT_RX_PEND] || mask[`CIVF_BIT_TX_PEND];

  // ----------------------------------------------------------------
  // CAN receive pin synchroniser
  // ----------------------------------------------------------------
  // Three stages; the stable level moves only when stages two and three agree,
  // which also rejects a single-cycle glitch on the pin
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      rx_meta     <= 1'b1;
      rx_sync2    <= 1'b1;
      rx_sync3    <= 1'b1;
      rx_stable   <= 1'b1;
      rx_stable_d <= 1'b1;
    end else begin
      rx_meta     <= i_can_rx;
      rx_sync2    <= rx_meta;
      rx_sync3    <= rx_sync2;
      if (rx_sync2 == rx_sync3) begin
        rx_stable <= rx_sync3;
      end
      rx_stable_d <= rx_stable;
    end
  end

  // ----------------------------------------------------------------
  // Timestamp timer
  // ----------------------------------------------------------------
  // Free running; the prescaler stretches each timer step
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      prescale_cnt      <= 16'h0000;
      o_timestamp_timer <= {TIMER_W{1'b0}};
    end else begin
      if (timer_tick) begin
        prescale_cnt      <= 16'h0000;
        o_timestamp_timer <= o_timestamp_timer + TIMER_ONE;
      end else begin
        prescale_cnt <= prescale_cnt + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode match history
  // ----------------------------------------------------------------
  // Reset to matched so that power-up does not look like a mode change
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      mode_match_d <= 1'b1;
    end else begin
      mode_match_d <= mode_match;
    end
  end

  // ----------------------------------------------------------------
  // Event collection
  // ----------------------------------------------------------------
  always @* begin
    flag_set = `CIVF_FLAG_RESET;
    flag_set[`CIVF_BIT_WAKE]    = i_sleep_mode && wake_edge;
    flag_set[`CIVF_BIT_BUS_ERR] = i_bus_error_event;
    flag_set[`CIVF_BIT_SYS_ERR] = i_address_error_event || i_bandwidth_error_event;
    flag_set[`CIVF_BIT_RX_OVF]  = i_receive_overflow_event;
    flag_set[`CIVF_BIT_MODE]    = mode_match && !mode_match_d;
    flag_set[`CIVF_BIT_TIMER]   = timer_wrap;
    flag_set[`CIVF_BIT_INVALID] = i_invalid_message_event;
  end

  // ----------------------------------------------------------------
  // Flag register next value
  // ----------------------------------------------------------------
  // Reading clears sticky bits, but a same-cycle event still wins
  always @* begin
    next_flags = flags;
    if (rd_flags) begin
      next_flags = flags & ~`CIVF_STICKY_MASK;
    end
    next_flags = (next_flags | flag_set) & `CIVF_STICKY_MASK;
    next_flags[`CIVF_BIT_RX_PEND] = i_receive_pending;
    next_flags[`CIVF_BIT_TX_PEND] = i_transmit_pending;
  end

  // ----------------------------------------------------------------
  // Flags, mask and system error detail
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      flags         <= `CIVF_FLAG_RESET;
      mask          <= `CIVF_FLAG_RESET;
      addr_err_pend <= 1'b0;
      bw_err_pend   <= 1'b0;
    end else begin
      flags <= next_flags;
      if (wr_mask) begin
        mask <= i_wdata[`CIVF_FLAG_W-1:0] & `CIVF_IMPL_MASK;
      end
      addr_err_pend <= (addr_err_pend && !rd_flags) || i_address_error_event;
      bw_err_pend   <= (bw_err_pend && !rd_flags) || i_bandwidth_error_event;
    end
  end

  // ----------------------------------------------------------------
  // FIFO source search
  // ----------------------------------------------------------------
  // Lowest numbered FIFO with its status bit set wins
  always @* begin
    fifo_idx = 5'h00;
    fifo_hit = 1'b0;
    for (k = `CIVF_FIFO_COUNT - 1; k >= 0; k = k - 1) begin
      if (i_fifo_interrupt_status[k]) begin
        fifo_idx = k[4:0];
        fifo_hit = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt code priority
  // ----------------------------------------------------------------
  // Fixed priority: bus errors first, FIFO traffic last, so a storm of
  // receive interrupts cannot hide a fault from software
  always @* begin
    if (enabled_flags[`CIVF_BIT_BUS_ERR]) begin
      next_interrupt_code = `CIVF_CODE_BUS_ERR;
    end else if (enabled_flags[`CIVF_BIT_WAKE]) begin
      next_interrupt_code = `CIVF_CODE_WAKE;
    end else if (enabled_flags[`CIVF_BIT_RX_OVF]) begin
      next_interrupt_code = `CIVF_CODE_RX_OVF;
    end else if (enabled_flags[`CIVF_BIT_SYS_ERR] && addr_err_pend) begin
      next_interrupt_code = `CIVF_CODE_ADDR_ERR;
    end else if (enabled_flags[`CIVF_BIT_SYS_ERR] && bw_err_pend) begin
      next_interrupt_code = `CIVF_CODE_BW_ERR;
    end else if (enabled_flags[`CIVF_BIT_TIMER]) begin
      next_interrupt_code = `CIVF_CODE_TIMER;
    end else if (enabled_flags[`CIVF_BIT_INVALID]) begin
      next_interrupt_code = `CIVF_CODE_INVALID;
    end else if (enabled_flags[`CIVF_BIT_MODE]) begin
      next_interrupt_code = `CIVF_CODE_MODE;
    end else if (fifo_enabled && fifo_hit) begin
      next_interrupt_code = {`CIVF_FIFO_PAD, fifo_idx};
    end else begin
      next_interrupt_code = `CIVF_CODE_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt code and filter hit registers
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      interrupt_code        <= `CIVF_CODE_NONE;
      matched_filter_number <= 5'h00;
    end else begin
      interrupt_code <= next_interrupt_code;
      if (i_filter_hit_valid) begin
        matched_filter_number <= i_filter_hit_number;
      end
    end
  end

  // ----------------------------------------------------------------
  // Filter control write filter
  // ----------------------------------------------------------------
  genvar f;
  generate
    for (f = 0; f < `CIVF_NUM_FILTERS; f = f + 1) begin : g_flt_wr
      localparam integer B = f * `CIVF_FLT_BYTE_W;
      always @* begin
        if (filter_control[B + `CIVF_FLT_EN_BIT]) begin
          next_filter_control[B +: `CIVF_FLT_BYTE_W] = filter_control[B +: `CIVF_FLT_BYTE_W];
          if (wr_filter) begin
            next_filter_control[B + `CIVF_FLT_EN_BIT] = i_wdata[B + `CIVF_FLT_EN_BIT];
          end
        end else if (wr_filter) begin
          next_filter_control[B +: `CIVF_FLT_BYTE_W] = i_wdata[B +: `CIVF_FLT_BYTE_W];
        end else begin
          next_filter_control[B +: `CIVF_FLT_BYTE_W] = filter_control[B +: `CIVF_FLT_BYTE_W];
        end
      end
    end
  endgenerate

  always @(posedge i_clk) begin
    if (!i_nrst) begin
      filter_control <= `CIVF_FLT_RESET;
    end else begin
      filter_control <= next_filter_control;
    end
  end

  // ----------------------------------------------------------------
  // Filter settings to the matching engine
  // ----------------------------------------------------------------
  // One cycle behind the register so every output is a flop
  generate
    for (f = 0; f < `CIVF_NUM_FILTERS; f = f + 1) begin : g_flt_out
      localparam integer B = f * `CIVF_FLT_BYTE_W;
      always @(posedge i_clk) begin
        if (!i_nrst) begin
          o_filter_enable[f]                                          <= 1'b0;
          o_filter_mask_decode[f*`CIVF_MASK_COUNT +: `CIVF_MASK_COUNT] <= 4'h0;
          o_filter_fifo_select[f*`CIVF_FLT_FIFO_SELECT_W +: `CIVF_FLT_FIFO_SELECT_W] <= 5'h00;
        end else begin
          o_filter_enable[f] <= filter_control[B + `CIVF_FLT_EN_BIT];
          case (filter_control[B + `CIVF_FLT_MASK_SELECT_LSB +: `CIVF_FLT_MASK_SELECT_W])
            2'h0:    o_filter_mask_decode[f*`CIVF_MASK_COUNT +: `CIVF_MASK_COUNT] <= 4'h1;
            2'h1:    o_filter_mask_decode[f*`CIVF_MASK_COUNT +: `CIVF_MASK_COUNT] <= 4'h2;
            2'h2:    o_filter_mask_decode[f*`CIVF_MASK_COUNT +: `CIVF_MASK_COUNT] <= 4'h4;
            default: o_filter_mask_decode[f*`CIVF_MASK_COUNT +: `CIVF_MASK_COUNT] <= 4'h8;
          endcase
          o_filter_fifo_select[f*`CIVF_FLT_FIFO_SELECT_W +: `CIVF_FLT_FIFO_SELECT_W] <=
            filter_control[B + `CIVF_FLT_FIFO_SELECT_LSB +: `CIVF_FLT_FIFO_SELECT_W];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read data mux
  // ----------------------------------------------------------------
  // Unmapped offsets read as zero; unused upper bits always zero
  always @* begin
    next_rdata = `CIVF_ZERO32;
    case (i_addr)
      `CIVF_OFS_INT_FLAGS: begin
        next_rdata[`CIVF_FLAG_W-1:0] = flags;
      end
      `CIVF_OFS_INT_MASK: begin
        next_rdata[`CIVF_FLAG_W-1:0] = mask;
      end
      `CIVF_OFS_INT_CODE: begin
        next_rdata[`CIVF_HIT_LSB +: `CIVF_HIT_W] = matched_filter_number;
        next_rdata[`CIVF_CODE_W-1:0] = interrupt_code;
      end
      `CIVF_OFS_FILTER_CTRL: begin
        next_rdata = filter_control;
      end
      default: next_rdata = `CIVF_ZERO32;
    endcase
  end

  // ----------------------------------------------------------------
  // Read data and interrupt line
  // ----------------------------------------------------------------
  // Read data held only in the cycle after the strobe
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      o_rdata <= `CIVF_ZERO32;
      o_irq   <= 1'b0;
    end else begin
      if (i_rd) begin
        o_rdata <= next_rdata;
      end else begin
        o_rdata <= `CIVF_ZERO32;
      end
      o_irq <= |(next_flags & mask);
    end
  end

endmodule

// file: tb/civf_monitor.sv
// Checker for the CAN interrupt code and filter control slice.
// Assumes it is bound into civf_top and sees only its ports.
`timescale 1ns/1ps
module civf_monitor #(
  parameter TIMER_W = 16
) (
  input wire               i_clk,
  input wire               i_nrst,
  input wire [3:0]         i_addr,
  input wire [31:0]        i_wdata,
  input wire               i_wr,
  input wire               i_rd,
  input wire               i_bus_error_event,
  input wire               i_receive_pending,
  input wire [31:0]        o_rdata,
  input wire [3:0]         o_filter_enable,
  input wire [15:0]        o_filter_mask_decode,
  input wire [19:0]        o_filter_fifo_select,
  input wire [TIMER_W-1:0] o_timestamp_timer
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // ----
  // Register port and codes
  // ----
  chk_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  chk_flag_layout: assert property (i_rd && i_addr == 4'h0 |=>
    o_rdata[31:16] == 16'h0000 && o_rdata[10:4] == 7'h00) else $error("unused flag bits set");
  chk_code_layout: assert property (i_rd && i_addr == 4'h8 |=>
    o_rdata[31:13] == 19'h00000 && !o_rdata[7]) else $error("unused code bits set");
  chk_code_legal: assert property (i_rd && i_addr == 4'h8 |=> o_rdata[6] ?
    o_rdata[5:0] inside {[6'h00:6'h06], 6'h08, 6'h0F} : !o_rdata[5]) else $error("reserved code");
  // The bench reads the flags five cycles after the event, with no flag read in between
  chk_bus_err_flag: assert property (i_bus_error_event ##1 !(i_rd && i_addr == 4'h0) [*4] ##1 (i_rd && i_addr == 4'h0)
    |=> o_rdata[13]) else $error("bus error flag missing");
  chk_rx_pend: assert property (i_rd && i_addr == 4'h0 |=> o_rdata[1] == $past(i_receive_pending, 2))
    else $error("receive pending bit wrong");
  chk_timer_wrap: assert property (&o_timestamp_timer |=> o_timestamp_timer == '0)
    else $error("timer did not wrap");
  // Filter 16 decode; a write while the filter is enabled changes only its enable bit
  chk_filt_decode: assert property (i_wr && i_addr == 4'hC && !i_wdata[7] && !o_filter_enable[0]
    ##1 !(i_wr && i_addr == 4'hC) |=> o_filter_mask_decode[3:0] == 4'h1 << $past(i_wdata[6:5], 2)
    && o_filter_fifo_select[4:0] == $past(i_wdata[4:0], 2)) else $error("filter 16 decode wrong");
  chk_filt_lock: assert property (o_filter_enable[0] |=>
    $stable(o_filter_fifo_select[4:0]) && $stable(o_filter_mask_decode[3:0])) else $error("locked filter changed");
endmodule

bind civf_top civf_monitor #(.TIMER_W(TIMER_W)) civf_monitor_inst (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_bus_error_event(i_bus_error_event),
  .i_receive_pending(i_receive_pending), .o_rdata(o_rdata), .o_filter_enable(o_filter_enable),
  .o_filter_mask_decode(o_filter_mask_decode), .o_filter_fifo_select(o_filter_fifo_select),
  .o_timestamp_timer(o_timestamp_timer));

// file: tb/civf_can_node.sv
// Behavioural CAN node that wakes a sleeping controller with bus activity.
// Assumes the bench pulses i_go for one clock; line is recessive otherwise.
`timescale 1ns/1ps
module civf_can_node #(
  parameter HOLD = 8
) (
  input  wire i_clk,
  input  wire i_go,
  output reg  o_rx
);
  int n = 0;
  // Dominant burst long enough to pass the pin synchroniser
  always @(posedge i_clk) begin
    if (i_go)
      n <= HOLD;
    else if (n > 0)
      n <= n - 1;
  end
  always @* o_rx = (n == 0);
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the CAN interrupt code and filter control slice.
// Assumes civf_top, its checker and the CAN node model are compiled first.
`timescale 1ns/1ps
module tb_top;
  logic        i_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic [3:0]  i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        sleep = 1'b0;
  logic [4:0]  ev = 5'h00;
  logic [2:0]  cur = 3'h0;
  logic [2:0]  req = 3'h0;
  logic        rp = 1'b0;
  logic        tp = 1'b0;
  logic [31:0] mfifo = 32'h0000_0000;
  logic        hv = 1'b0;
  logic [4:0]  hn = 5'h00;
  logic        go = 1'b0;
  wire         can_rx;
  wire  [31:0] o_rdata;
  wire         o_irq;
  wire  [3:0]  fen;
  wire  [15:0] fmd;
  wire  [19:0] ffs;
  wire  [15:0] tmr;
  int          mflags = 0, mmask = 0, mflt = 0, mhit = 0, msys = 0;
  int          fails = 0, total_checks = 0, seed = 77, d, n;
  int          fbit[5] = '{13, 12, 12, 11, 15};
  int          fcode[5] = '{8'h41, 8'h44, 8'h45, 8'h43, 8'h48};

  civf_top #(.TIMER_W(16)) civf_top_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_can_rx(can_rx), .i_sleep_mode(sleep),
    .i_bus_error_event(ev[0]), .i_address_error_event(ev[1]), .i_bandwidth_error_event(ev[2]),
    .i_receive_overflow_event(ev[3]), .i_invalid_message_event(ev[4]), .i_current_operating_mode(cur),
    .i_requested_operating_mode(req), .i_receive_pending(rp), .i_transmit_pending(tp),
    .i_fifo_interrupt_status(mfifo), .i_filter_hit_valid(hv), .i_filter_hit_number(hn),
    .o_filter_enable(fen), .o_filter_mask_decode(fmd), .o_filter_fifo_select(ffs), .o_timestamp_timer(tmr));
  civf_can_node #(.HOLD(8)) civf_can_node_inst (.i_clk(i_clk), .i_go(go), .o_rx(can_rx));

  always #4 i_clk = ~i_clk;

  // ----
  // Reference model and bus tasks
  // ----
  function automatic int code_of();
    int p;
    p = mflags & mmask;
    if (p[13]) return 8'h41;
    if (p[14]) return 8'h42;
    if (p[11]) return 8'h43;
    if (p[12]) return msys;
    if (p[2]) return 8'h46;
    if (p[15]) return 8'h48;
    if (p[3]) return 8'h4F;
    if (mmask & 3) for (int i = 0; i < 32; i++) if (mfifo[i]) return i;
    return 8'h40;
  endfunction
  function automatic logic [31:0] exp_rd(input logic [3:0] a);
    case (a)
      4'h0: return mflags | (rp << 1) | tp;
      4'h4: return mmask;
      4'h8: return (mhit << 8) | code_of();
      4'hC: return mflt;
      default: return 32'h0000_0000;
    endcase
  endfunction
  // Wide enough for the 40-bit filter output bundle
  task automatic cmp(input string nm, input logic [39:0] e, input logic [39:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [3:0] a);
    logic [31:0] e;
    e = exp_rd(a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 cmp("read", e, o_rdata);
    // A read of the flags clears every sticky bit
    if (a == 4'h0) mflags = 0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
    if (a == 4'h4) mmask = v & 32'h0000_F80F;
    // Enabled filters keep their selects, only the enable is taken
    if (a == 4'hC) for (int f = 0; f < 32; f += 8) mflt[f+:8] = mflt[f+7] ? {v[f+7], mflt[f+:7]} : v[f+:8];
  endtask
  task automatic pulse(input int k);
    @(posedge i_clk);
    ev <= 5'h01 << k;
    @(posedge i_clk);
    ev <= 5'h00;
    mflags |= 1 << fbit[k];
    if (fbit[k] == 12) msys = fcode[k];
  endtask
  task automatic irqchk;
    @(posedge i_clk);
    #1 cmp("irq", {31'h0, ((mflags | (rp << 1) | tp) & mmask) != 0}, {31'h0, o_irq});
  endtask
  task automatic fltchk;
    logic [15:0] md;
    logic [19:0] fs;
    rd(4'hC);
    for (int f = 0; f < 4; f++) begin
      md[4*f+:4] = 4'h1 << mflt[8*f+5+:2];
      fs[5*f+:5] = mflt[8*f+:5];
    end
    cmp("filter", {mflt[31], mflt[23], mflt[15], mflt[7], md, fs}, {fen, fmd, ffs});
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    repeat (5) @(posedge i_clk);
    i_nrst <= 1'b1;
    wr(4'h2, 32'hFFFF_FFFF);
    for (int a = 0; a < 16; a += 2) rd(a[3:0]);
    fltchk;
    $display("reset values done");
    wr(4'h4, 32'hFFFF_FFFF);
    rd(4'h4);
    for (int k = 0; k < 5; k++) begin
      pulse(k);
      irqchk;
      rd(4'h8);
      rd(4'h0);
      irqchk;
    end
    wr(4'h4, 32'h0000_D80F);
    pulse(0);
    irqchk;
    rd(4'h8);
    rd(4'h0);
    wr(4'h4, 32'h0000_F80F);
    $display("event codes done");
    @(posedge i_clk);
    sleep <= 1'b1;
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    repeat (16) @(posedge i_clk);
    sleep <= 1'b0;
    req <= 3'h5;
    mflags |= 32'h0000_4000;
    rd(4'h8);
    rd(4'h0);
    @(posedge i_clk);
    cur <= 3'h5;
    repeat (3) @(posedge i_clk);
    mflags |= 32'h0000_0008;
    rd(4'h8);
    rd(4'h0);
    $display("wake and mode done");
    for (int i = 0; i < 4; i++) begin
      @(posedge i_clk);
      d = $random(seed);
      mfifo <= (i == 0) ? 32'h8000_0000 : (i == 3) ? 32'h0000_0000 : d;
      {tp, rp} <= i[1:0];
      hv <= 1'b1;
      hn <= (i == 1) ? 5'h1F : d[9:5];
      @(posedge i_clk);
      hv <= 1'b0;
      mhit = hn;
      rd(4'h8);
      rd(4'h0);
    end
    $display("fifo codes done");
    wr(4'hC, 32'h7F5F_3F1F);
    fltchk;
    d = $random(seed);
    wr(4'hC, d & 32'h7F7F_7F7F);
    fltchk;
    wr(4'hC, mflt | 32'h8080_8080);
    wr(4'hC, 32'h0000_0000);
    fltchk;
    wr(4'hC, 32'h0000_0000);
    fltchk;
    $display("filter control done");
    // Look just after each edge so the timer value has settled
    for (n = 0; n < 70000 && tmr !== 16'hFFFF; n++) begin
      @(posedge i_clk);
      #1;
    end
    if (n == 70000) begin
      fails++;
    end else begin
      repeat (3) @(posedge i_clk);
      mflags |= 32'h0000_0004;
      rd(4'h8);
      rd(4'h0);
      $display("timer wrap done");
    end
    final_report;
  end
endmodule
